// File: rtl/mbcd_pkg.sv
package mbcd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int PC_W   = 12;
    localparam int DATA_W = 8;
    localparam int RAM_AW = 7;
    localparam int SP_W   = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Opcodes and opcode fields.
    localparam logic [7:0] OP_JUMP_TEST0_HIGH    = 8'h36;
    localparam logic [7:0] OP_JUMP_TEST0_LOW     = 8'h26;
    localparam logic [7:0] OP_JUMP_TEST1_LOW     = 8'h46;
    localparam logic [7:0] OP_JUMP_USER_FLAG_ONE = 8'h76;
    localparam logic [7:0] OP_JUMP_ON_IRQ_PIN    = 8'h86;
    localparam logic [7:0] OP_CLOCK_OUT_ENABLE   = 8'h75;
    localparam logic [7:0] OP_HALT               = 8'h01;
    localparam logic [4:0] OP_ACC_BIT_LOW        = 5'h12;
    localparam logic [4:0] OP_CALL_LOW           = 5'h14;
    localparam logic [6:0] OP_NIBBLE_XCHG_HIGH   = 7'h18;
    localparam logic [6:0] OP_EXT_WRITE_HIGH     = 7'h48;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values, addresses and timing counts.
    localparam logic [PC_W-1:0]   PC_RESET     = 12'h000;
    localparam logic [SP_W-1:0]   SP_RESET     = 3'h0;
    localparam logic [DATA_W-1:0] ACC_RESET    = 8'h00;
    localparam logic [RAM_AW-1:0] STACK_BASE   = 7'h08;
    localparam logic [1:0]        CLK_DIV_LAST = 2'h2;

    typedef enum logic [2:0] {
        ST_FETCH, ST_OPC, ST_ARG, ST_PUSH, ST_PTR, ST_DATA, ST_HALT
    } mbcd_state_e;

    typedef struct packed {
        mbcd_state_e        st;
        logic [7:0]         op;
        logic [PC_W-1:0]    pc;
        logic [SP_W-1:0]    sp;
        logic [DATA_W-1:0]  acc;
        logic [RAM_AW-1:0]  ptr;
        logic [7:0]         arg;
        logic               push_hi;
        logic               rd;
        logic [7:0]         ext_addr;
        logic [7:0]         ext_wdata;
        logic               ext_wr;
        logic               clk_en;
        logic [1:0]         div;
        logic               clk_out;
        logic               halted;
    } mbcd_core_s;

endpackage : mbcd_pkg

// File: rtl/mbcd_ram_if.sv
`timescale 1ns/1ns
interface mbcd_ram_if;
    import mbcd_pkg::*;
    logic [RAM_AW-1:0] addr;
    logic              we;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    modport master (output addr, output we, output wdata, input rdata);
    modport slave  (input addr, input we, input wdata, output rdata);
endinterface : mbcd_ram_if

// File: rtl/mbcd_sync.sv
`timescale 1ns/1ns
module mbcd_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rst_b_i,
    // Pin side and clean side
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } mbcd_sync_s;

    mbcd_sync_s r;
    mbcd_sync_s next_r;

    // A change is accepted only once the second and third stages agree.
    always_comb begin
        next_r    = r;
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q  = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= {INIT, INIT, INIT, INIT};
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.q;

endmodule : mbcd_sync

// File: rtl/mbcd_ram.sv
`timescale 1ns/1ns
module mbcd_ram #(
    parameter int DEPTH = 128
) (
    // Clock
    input  wire logic   sys_clk_i,
    // Port
    mbcd_ram_if.slave   bus
);
    import mbcd_pkg::*;

    logic [DATA_W-1:0] mem [0:DEPTH-1];

    // The array sits in a plain clocked process so that test code may preload it.
    always @(posedge sys_clk_i) begin
        if (bus.we) begin
            mem[bus.addr] <= bus.wdata;
        end
    end

    // Read-before-write: a write cycle returns the old byte next cycle.
    always_ff @(posedge sys_clk_i) begin
        bus.rdata <= mem[bus.addr];
    end

endmodule : mbcd_ram

// File: rtl/mbcd_core.sv
`timescale 1ns/1ns
// Function
// RULE_01 - Opcode 36h loads the second byte into PC[7:0] when test pin zero is high.
// RULE_02 - Opcode 26h loads the second byte into PC[7:0] when test pin zero is low.
// RULE_03 - Opcode 46h loads the second byte into PC[7:0] when test pin one is low.
// RULE_04 - Opcode 76h loads the second byte into PC[7:0] when user flag one is set.
// RULE_05 - Opcode 86h branches in page when the interrupt pin is low.
// RULE_06 - Opcode bbb10010 branches in page when accumulator bit bbb is one.
// RULE_07 - A call pushes status word bits 7 to 4 and the PC, bumps the stack pointer and jumps.
// RULE_08 - Nibble exchange swaps low nibbles of the accumulator and RAM at R0 or R1.
// RULE_09 - External data write sends the accumulator to the address in R0 or R1.
// RULE_10 - Opcode 75h turns test pin zero into a clock output in one cycle.
// RULE_11 - Opcode 01h is decoded as halt.
// RULE_12 - Halt freezes all state until reset or a low interrupt pin.
// RULE_13 - In-page jumps never change PC[11:8].
module mbcd_core (
    // Clock and reset
    input  wire logic                         sys_clk_i,
    input  wire logic                         rst_b_i,
    // Program memory
    output logic [mbcd_pkg::PC_W-1:0]         prog_addr_o,
    output logic                              prog_rd_o,
    input  wire logic [mbcd_pkg::DATA_W-1:0]  prog_data_i,
    // External data memory
    output logic [7:0]                        ext_addr_o,
    output logic [mbcd_pkg::DATA_W-1:0]       ext_wdata_o,
    output logic                              ext_wr_o,
    // Pins
    input  wire logic                         test_pin_zero_i,
    output logic                              test_pin_zero_o,
    output logic                              test_pin_zero_oe_o,
    input  wire logic                         test_pin_one_i,
    input  wire logic                         irq_pin_b_i,
    // Core state from neighbouring logic
    input  wire logic                         user_flag_one_i,
    input  wire logic                         memory_bank_flipflop_i,
    input  wire logic [3:0]                   program_status_upper_i,
    input  wire logic                         acc_load_i,
    input  wire logic [mbcd_pkg::DATA_W-1:0]  acc_data_i,
    // Status
    output logic [mbcd_pkg::DATA_W-1:0]       acc_o,
    output logic [mbcd_pkg::SP_W-1:0]         sp_o,
    output logic                              halted_o
);
    import mbcd_pkg::*;

    mbcd_core_s        r;
    mbcd_core_s        next_r;
    logic [2:0]        pins;
    logic              pin_zero;
    logic              pin_one;
    logic              irq_b;
    logic              take;
    logic [RAM_AW-1:0] ram_addr;
    logic              ram_we;
    logic [DATA_W-1:0] ram_wdata;

    mbcd_ram_if ram ();

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs come from outside the clock domain.
    mbcd_sync #(
        .W    (3),
        .INIT (3'h4)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .d_i       ({irq_pin_b_i, test_pin_one_i, test_pin_zero_i}),
        .q_o       (pins)
    );

    assign pin_zero = pins[0];
    assign pin_one  = pins[1];
    assign irq_b    = pins[2];

    mbcd_ram #(
        .DEPTH (128)
    ) u_ram (
        .sys_clk_i (sys_clk_i),
        .bus       (ram)
    );

    assign ram.addr  = ram_addr;
    assign ram.we    = ram_we;
    assign ram.wdata = ram_wdata;

    ////////////////////////////////////////////////////////////////////////////
    // Branch condition of the conditional jump held in r.op.
    always_comb begin
        case (r.op)
            OP_JUMP_TEST0_HIGH:    take = pin_zero;                  // RULE_01
            OP_JUMP_TEST0_LOW:     take = ~pin_zero;                 // RULE_02
            OP_JUMP_TEST1_LOW:     take = ~pin_one;                  // RULE_03
            OP_JUMP_USER_FLAG_ONE: take = user_flag_one_i;           // RULE_04
            OP_JUMP_ON_IRQ_PIN:    take = ~irq_b;                    // RULE_05
            default: begin
                take = (r.op[4:0] == OP_ACC_BIT_LOW) && r.acc[r.op[7:5]]; // RULE_06
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_comb begin
        next_r        = r;
        next_r.ext_wr = 1'b0;
        ram_addr      = {RAM_AW{1'b0}};
        ram_we        = 1'b0;
        ram_wdata     = r.acc;
        // Halt freezes the accumulator too; a load strobe during halt is dropped.
        if (acc_load_i && r.st != ST_HALT) begin
            next_r.acc = acc_data_i;
        end
        case (r.st)
            ST_FETCH: begin
                next_r.pc = r.pc + 12'h001;
                next_r.st = ST_OPC;
            end
            ST_OPC: begin
                next_r.op = prog_data_i;
                if (prog_data_i == OP_JUMP_TEST0_HIGH || prog_data_i == OP_JUMP_TEST0_LOW ||
                    prog_data_i == OP_JUMP_TEST1_LOW || prog_data_i == OP_JUMP_ON_IRQ_PIN ||
                    prog_data_i == OP_JUMP_USER_FLAG_ONE ||
                    prog_data_i[4:0] == OP_ACC_BIT_LOW || prog_data_i[4:0] == OP_CALL_LOW) begin
                    next_r.pc = r.pc + 12'h001;
                    next_r.st = ST_ARG;
                end else if (prog_data_i[7:1] == OP_NIBBLE_XCHG_HIGH ||
                             prog_data_i[7:1] == OP_EXT_WRITE_HIGH) begin
                    ram_addr  = {{(RAM_AW-1){1'b0}}, prog_data_i[0]};
                    next_r.st = ST_PTR;
                end else if (prog_data_i == OP_CLOCK_OUT_ENABLE) begin
                    next_r.clk_en = 1'b1;                            // RULE_10
                    next_r.st    = ST_FETCH;
                end else if (prog_data_i == OP_HALT) begin
                    next_r.st = ST_HALT;                             // RULE_11
                end else begin
                    // Opcodes owned by other decode blocks pass as one fetch.
                    next_r.st = ST_FETCH;
                end
            end
            ST_ARG: begin
                next_r.arg = prog_data_i;
                if (r.op[4:0] == OP_CALL_LOW) begin
                    next_r.push_hi = 1'b0;
                    next_r.st      = ST_PUSH;
                end else begin
                    if (take) begin
                        next_r.pc = {r.pc[11:8], prog_data_i};       // RULE_13
                    end
                    next_r.st = ST_FETCH;
                end
            end
            ST_PUSH: begin
                // Two stack bytes per level: PC low, then PROGRAM_STATUS_WORD upper and PC high.
                ram_we    = 1'b1;                                    // RULE_07
                ram_addr  = STACK_BASE + {{(RAM_AW-SP_W-1){1'b0}}, r.sp, r.push_hi};
                ram_wdata = r.push_hi ? {program_status_upper_i, r.pc[11:8]} : r.pc[7:0];
                if (!r.push_hi) begin
                    next_r.push_hi = 1'b1;
                end else begin
                    next_r.sp = r.sp + 3'h1;                         // RULE_07
                    next_r.pc = {memory_bank_flipflop_i, r.op[7:5], r.arg}; // RULE_07
                    next_r.st = ST_FETCH;
                end
            end
            ST_PTR: begin
                if (r.op[7:1] == OP_EXT_WRITE_HIGH) begin
                    next_r.ext_addr  = ram.rdata;                    // RULE_09
                    next_r.ext_wdata = r.acc;
                    next_r.ext_wr    = 1'b1;
                    next_r.st        = ST_FETCH;
                end else begin
                    next_r.ptr = ram.rdata[RAM_AW-1:0];
                    ram_addr   = ram.rdata[RAM_AW-1:0];
                    next_r.st  = ST_DATA;
                end
            end
            ST_DATA: begin
                ram_we     = 1'b1;                                   // RULE_08
                ram_addr   = r.ptr;
                ram_wdata  = {ram.rdata[7:4], r.acc[3:0]};
                next_r.acc = {r.acc[7:4], ram.rdata[3:0]};
                next_r.st  = ST_FETCH;
            end
            ST_HALT: begin
                // Everything holds; only a low interrupt pin moves on.
                if (!irq_b) begin
                    next_r.st = ST_FETCH;                            // RULE_12
                end
            end
            default: begin
                next_r.st = ST_FETCH;
            end
        endcase
        // The test pin clock is an internal clock, so it freezes in halt.
        if (r.clk_en && r.st != ST_HALT) begin
            next_r.div = (r.div == CLK_DIV_LAST) ? 2'h0 : r.div + 2'h1;
        end
        next_r.clk_out = r.clk_en && (next_r.div == 2'h0);
        // The opcode slot also fetches the following byte, so a second byte is ready in ST_ARG.
        next_r.rd      = (next_r.st == ST_FETCH) || (next_r.st == ST_OPC);
        next_r.halted  = (next_r.st == ST_HALT);
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '{st: ST_FETCH, op: 8'h00, pc: PC_RESET, sp: SP_RESET, acc: ACC_RESET,
                   ptr: 7'h00, arg: 8'h00, push_hi: 1'b0, rd: 1'b1, ext_addr: 8'h00,
                   ext_wdata: 8'h00, ext_wr: 1'b0, clk_en: 1'b0, div: 2'h0, clk_out: 1'b0,
                   halted: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign prog_addr_o        = r.pc;
    assign prog_rd_o          = r.rd;
    assign ext_addr_o         = r.ext_addr;
    assign ext_wdata_o        = r.ext_wdata;
    assign ext_wr_o           = r.ext_wr;
    assign test_pin_zero_o    = r.clk_out;
    assign test_pin_zero_oe_o = r.clk_en;
    assign acc_o              = r.acc;
    assign sp_o               = r.sp;
    assign halted_o           = r.halted;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_test0_high: assert property ( // RULE_01
        (r.st == ST_ARG && r.op == OP_JUMP_TEST0_HIGH)
        |=> r.pc == ($past(pin_zero) ? {$past(r.pc[11:8]), $past(prog_data_i)} : $past(r.pc)))
        else $error("test0 high jump wrong target");

    a_test0_low: assert property ( // RULE_02
        (r.st == ST_ARG && r.op == OP_JUMP_TEST0_LOW && !pin_zero)
        |=> r.pc[7:0] == $past(prog_data_i) && r.st == ST_FETCH)
        else $error("test0 low jump not taken");

    a_test1_low: assert property ( // RULE_03
        (r.st == ST_ARG && r.op == OP_JUMP_TEST1_LOW && pin_one) |=> r.pc == $past(r.pc))
        else $error("test1 low jump taken with pin high");

    a_flag_one: assert property ( // RULE_04
        (r.st == ST_ARG && r.op == OP_JUMP_USER_FLAG_ONE && user_flag_one_i)
        |=> r.pc[7:0] == $past(prog_data_i))
        else $error("flag one jump not taken");

    a_irq_pin: assert property ( // RULE_05
        (r.st == ST_ARG && r.op == OP_JUMP_ON_IRQ_PIN && !irq_b)
        |=> r.pc[7:0] == $past(prog_data_i))
        else $error("interrupt pin jump not taken");

    a_accbit_branch: assert property ( // RULE_06
        (r.st == ST_ARG && r.op[4:0] == OP_ACC_BIT_LOW && !r.acc[r.op[7:5]])
        |=> r.pc == $past(r.pc))
        else $error("accumulator bit jump taken on zero bit");

    a_page_kept: assert property ( // RULE_13
        (r.st == ST_ARG && r.op[4:0] != OP_CALL_LOW) |=> r.pc[11:8] == $past(r.pc[11:8]))
        else $error("in-page jump changed page");

    a_call_push: assert property ( // RULE_07
        (r.st == ST_ARG && r.op[4:0] == OP_CALL_LOW)
        |=> ram_we ##1 ram_we ##1 (r.sp == $past(r.sp, 3) + 3'h1
            && r.pc[11] == $past(memory_bank_flipflop_i) && r.pc[10:8] == r.op[7:5]))
        else $error("call push or target wrong");

    a_nibble_swap: assert property ( // RULE_08
        (r.st == ST_DATA && !acc_load_i)
        |=> r.acc == {$past(r.acc[7:4]), $past(ram.rdata[3:0])})
        else $error("nibble exchange wrong accumulator");

    a_ext_write: assert property ( // RULE_09
        (r.st == ST_PTR && r.op[7:1] == OP_EXT_WRITE_HIGH)
        |=> ext_wr_o && ext_addr_o == $past(ram.rdata) && ext_wdata_o == $past(r.acc)
            ##1 !ext_wr_o)
        else $error("external write wrong");

    a_clkout_enable: assert property ( // RULE_10
        (r.st == ST_OPC && prog_data_i == OP_CLOCK_OUT_ENABLE)
        |=> test_pin_zero_oe_o && r.st == ST_FETCH)
        else $error("clock output not enabled");

    a_halt_hold: assert property ( // RULE_12
        (halted_o && irq_b) |=> halted_o && $stable(r.pc) && $stable(r.acc) && $stable(r.sp))
        else $error("state moved during halt");

    a_halt_entry: assert property ( // RULE_11
        (r.st == ST_OPC && prog_data_i == OP_HALT) |=> halted_o [*2] or (halted_o ##1 !irq_b))
        else $error("halt opcode not decoded");

endmodule : mbcd_core

// File: tb/mbcd_prog_model.sv
`timescale 1ns/1ns
module mbcd_prog_model (
    // Clock
    input  wire logic                        sys_clk_i,
    // Fetch port
    input  wire logic                        prog_rd_i,
    input  wire logic [mbcd_pkg::PC_W-1:0]   prog_addr_i,
    output logic      [7:0]                  prog_data_o
);
    import mbcd_pkg::*;

    logic [7:0] mem [0:4095];
    logic       hit [0:4095];

    // A released bus inverts its byte on every edge, so a late sample alternates between the last byte and its inverse.
    always @(posedge sys_clk_i) begin
        if (prog_rd_i) begin
            prog_data_o      <= mem[prog_addr_i];
            hit[prog_addr_i] <= 1'b1;
        end else begin
            prog_data_o <= ~prog_data_o;
        end
    end
endmodule : mbcd_prog_model

// File: tb/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    import mbcd_pkg::*;

    logic              sys_clk = 1'b0;
    logic              rst_b   = 1'b0;
    logic [7:0]        pdata;
    logic              pin0_drv = 1'b0, clk_out, clk_oe, pin1 = 1'b1, irq_b = 1'b1;
    logic              flag1 = 1'b0, bank = 1'b0, acc_ld = 1'b0;
    logic [3:0]        status_up = 4'h5;
    logic [7:0]        acc_d = 8'h00, ext_a, ext_d, acc;
    logic [PC_W-1:0]   paddr;
    logic              prd, ext_wr, halted;
    logic [SP_W-1:0]   sp;
    wire logic         pin0 = clk_oe ? clk_out : pin0_drv;
    int                mismatches = 0;
    int                n_tests = 0;
    int                cycles = 0;

    always #20 sys_clk = ~sys_clk;

    mbcd_core dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .prog_addr_o(paddr), .prog_rd_o(prd),
        .prog_data_i(pdata), .ext_addr_o(ext_a), .ext_wdata_o(ext_d), .ext_wr_o(ext_wr),
        .test_pin_zero_i(pin0), .test_pin_zero_o(clk_out), .test_pin_zero_oe_o(clk_oe),
        .test_pin_one_i(pin1), .irq_pin_b_i(irq_b), .user_flag_one_i(flag1),
        .memory_bank_flipflop_i(bank), .program_status_upper_i(status_up),
        .acc_load_i(acc_ld),
        .acc_data_i(acc_d), .acc_o(acc), .sp_o(sp), .halted_o(halted));

    mbcd_prog_model pmem (.sys_clk_i(sys_clk), .prog_rd_i(prd), .prog_addr_i(paddr),
        .prog_data_o(pdata));

    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // The whole run needs about 1400 cycles; the ceiling leaves ample margin.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task hold;
        @(posedge sys_clk);
        rst_b <= 1'b0;
        // Clear one edge into reset, so that no fetch of the old program marks a hit.
        @(posedge sys_clk);
        for (int i = 0; i < 4096; i++) begin
            pmem.mem[i] = 8'h00;
            pmem.hit[i] = 1'b0;
        end
    endtask : hold

    // The pin synchronisers show reset values until four edges after release; every
    // scenario tests its pins later than that.
    task boot(input logic [7:0] accv);
        repeat (5) @(posedge sys_clk);
        rst_b  <= 1'b1;
        acc_ld <= 1'b1;
        acc_d  <= accv;
        @(posedge sys_clk);
        acc_ld <= 1'b0;
    endtask : boot

    // A call moves execution to page 3 so that a page slip shows up as a wrong fetch.
    task run_jump(input logic [7:0] op, input logic p0v, p1v, flagv, irqv,
                  input logic [7:0] accv, output logic [1:0] seen);
        hold();
        pmem.mem[0] = 8'h74;
        pmem.mem[1] = 8'h00;
        pmem.mem[12'h300] = op;
        pmem.mem[12'h301] = 8'h80;
        pin0_drv <= p0v;
        pin1     <= p1v;
        flag1    <= flagv;
        irq_b    <= irqv;
        bank   <= 1'b0;
        boot(accv);
        repeat (40) @(posedge sys_clk);
        seen = {pmem.hit[12'h380], pmem.hit[12'h302]};
    endtask : run_jump

    ////////////////////////////////////////////////////////////////////////////
    task t_pin_jumps;
        logic [1:0] s;
        run_jump(OP_JUMP_TEST0_HIGH, 1, 1, 0, 1, 0, s);    `CHK("pin0 high taken", 2'b10, s)
        run_jump(OP_JUMP_TEST0_HIGH, 0, 1, 0, 1, 0, s);    `CHK("pin0 high fall", 2'b01, s)
        run_jump(OP_JUMP_TEST0_LOW, 0, 1, 0, 1, 0, s);     `CHK("pin0 low taken", 2'b10, s)
        run_jump(OP_JUMP_TEST0_LOW, 1, 1, 0, 1, 0, s);     `CHK("pin0 low fall", 2'b01, s)
        run_jump(OP_JUMP_TEST1_LOW, 1, 0, 0, 1, 0, s);     `CHK("pin1 low taken", 2'b10, s)
        run_jump(OP_JUMP_TEST1_LOW, 0, 1, 0, 1, 0, s);     `CHK("pin1 low fall", 2'b01, s)
        run_jump(OP_JUMP_USER_FLAG_ONE, 0, 1, 1, 1, 0, s); `CHK("flag taken", 2'b10, s)
        run_jump(OP_JUMP_USER_FLAG_ONE, 1, 0, 0, 1, 0, s); `CHK("flag fall", 2'b01, s)
        run_jump(OP_JUMP_ON_IRQ_PIN, 0, 1, 0, 0, 0, s);    `CHK("irq taken", 2'b10, s)
        run_jump(OP_JUMP_ON_IRQ_PIN, 0, 1, 1, 1, 0, s);    `CHK("irq fall", 2'b01, s)
    endtask : t_pin_jumps

    task t_acc_bit_jumps;
        logic [1:0] s;
        logic [2:0] b;
        for (int i = 0; i < 8; i++) begin
            b = 3'(i);
            run_jump({b, OP_ACC_BIT_LOW}, 0, 1, 0, 1, 8'h01 << i, s);
            `CHK("acc bit taken", 2'b10, s)
            run_jump({b, OP_ACC_BIT_LOW}, 0, 1, 0, 1, ~(8'h01 << i), s);
            `CHK("acc bit fall", 2'b01, s)
        end
    endtask : t_acc_bit_jumps

    task t_call;
        hold();
        pmem.mem[0] = {3'h5, OP_CALL_LOW};
        pmem.mem[1] = 8'h55;
        pmem.mem[12'hd55] = {3'h0, OP_CALL_LOW};
        pmem.mem[12'hd56] = 8'h20;
        bank      <= 1'b1;
        status_up <= 4'ha;
        boot(8'h00);
        repeat (30) @(posedge sys_clk);
        #1;
        `CHK("call target", 2'b10, {pmem.hit[12'hd55], pmem.hit[12'h555]})
        `CHK("nested target", 1'b1, pmem.hit[12'h820])
        `CHK("stack pointer", 3'h2, sp)
        `CHK("stack low byte", 8'h02, dut.u_ram.mem[8])
        `CHK("stack status byte", 8'ha0, dut.u_ram.mem[9])
        `CHK("nested low byte", 8'h57, dut.u_ram.mem[10])
        `CHK("nested status byte", 8'had, dut.u_ram.mem[11])
    endtask : t_call

    // Exchange, write, exchange: the second swap must give back the accumulator and RAM byte.
    task t_exchange_write;
        int pulses;
        hold();
        pmem.mem[0] = {OP_NIBBLE_XCHG_HIGH, 1'b0};
        pmem.mem[1] = {OP_EXT_WRITE_HIGH, 1'b1};
        pmem.mem[2] = {OP_NIBBLE_XCHG_HIGH, 1'b0};
        dut.u_ram.mem[0]     = 8'h20;
        dut.u_ram.mem[1]     = 8'h44;
        dut.u_ram.mem[7'h20] = 8'h3c;
        boot(8'ha5);
        pulses = 0;
        for (int i = 0; i < 30; i++) begin
            @(posedge sys_clk);
            #1;
            if (ext_wr === 1'b1) begin
                pulses++;
                `CHK("write data", 8'hac, ext_d)
                `CHK("write address", 8'h44, ext_a)
                `CHK("acc swapped", 8'hac, acc)
            end
        end
        `CHK("write pulses", 1, pulses)
        `CHK("acc restored", 8'ha5, acc)
        `CHK("ram restored", 8'h3c, dut.u_ram.mem[7'h20])
    endtask : t_exchange_write

    task t_clock_out;
        int highs;
        hold();
        pmem.mem[0] = OP_CLOCK_OUT_ENABLE;
        boot(8'h00);
        repeat (10) @(posedge sys_clk);
        #1;
        `CHK("pin drive", 1'b1, clk_oe)
        highs = 0;
        for (int i = 0; i < 9; i++) begin
            @(posedge sys_clk);
            #1;
            if (clk_out === 1'b1) highs++;
        end
        `CHK("clock highs", 3, highs)
    endtask : t_clock_out

    task t_halt;
        hold();
        pmem.mem[0] = OP_HALT;
        irq_b <= 1'b1;
        boot(8'h3c);
        repeat (20) @(posedge sys_clk);
        #1;
        `CHK("halted", 1'b1, halted)
        `CHK("pc frozen", 12'h001, paddr)
        `CHK("no fetch", 1'b0, pmem.hit[12'h002])
        `CHK("acc kept", 8'h3c, acc)
        @(posedge sys_clk);
        irq_b <= 1'b0;
        repeat (12) @(posedge sys_clk);
        #1;
        `CHK("released", 1'b0, halted)
        `CHK("resumed", 1'b1, pmem.hit[12'h002])
        irq_b <= 1'b1;
    endtask : t_halt

    initial begin
        t_pin_jumps();
        t_acc_bit_jumps();
        t_call();
        t_exchange_write();
        t_clock_out();
        t_halt();
        end_of_test();
    end
endmodule : testbench
